//--- design/coam_pkg.sv
/*
  package for the cpu operand address block: addressing modes, byte counts, address constants.
  assumes a single 10 MHz clock domain and a synchronous-read program/data memory.
*/
package coam_pkg;
  typedef enum logic [3:0] {
    COAM_INH, COAM_IMM, COAM_DIR, COAM_EXT, COAM_IX0, COAM_IX1, COAM_IX2, COAM_REL, COAM_UNSIGNED_MULTIPLY_OP
  } coam_mode_e;
  localparam logic [7:0] COAM_ZERO_PAGE = 8'h00;
  localparam logic [1:0] COAM_LEN_ONE = 2'h1;
  localparam logic [1:0] COAM_LEN_TWO = 2'h2;
  localparam logic [1:0] COAM_LEN_THREE = 2'h3;
  localparam logic [15:0] COAM_ADDR_ONE = 16'h0001;
endpackage : coam_pkg

//--- design/coam_operand_addr.sv
/*
  operand fetch and effective-address generation, with the unsigned multiply.
  assumes memory returns mem_rdata one cycle after mem_rd with mem_addr; the caller holds
  start for one cycle with mode, pc (address of the opcode), index and accumulator stable
  until done.
*/
`timescale 1ns/1ps
// Function
// [RQ1] inherent: one byte, no operand address
// [RQ2] immediate: two bytes, operand used directly
// [RQ3] direct: second byte low, high byte zero
// [RQ4] extended: three bytes, high then low
// [RQ5] indexed no offset: index as low address
// [RQ6] indexed 8-bit: index plus offset, keep carry
// [RQ7] indexed 16-bit: offset high first, add index
// [RQ8] relative: taken branch adds signed offset to pc
// [RQ9] multiply: high byte to index, low to accumulator
// [RQ10] 16-bit sums wrap modulo 65536
module coam_operand_addr
  import coam_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // request
  input wire logic start,
  input wire coam_mode_e mode,
  input wire logic [15:0] pc,
  input wire logic [7:0] index_in,
  input wire logic [7:0] acc_in,
  input wire logic branch_cond,
  // memory
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // answer
  output logic done,
  output logic [1:0] inst_len,
  output logic addr_valid,
  output logic [15:0] eff_addr,
  output logic [7:0] imm_data,
  output logic [15:0] next_pc,
  output logic [7:0] acc_out,
  output logic [7:0] index_out
);
  typedef enum logic [1:0] {COAM_IDLE, COAM_B1, COAM_B2, COAM_FIN} coam_state_e;

  function automatic logic [15:0] coam_add16(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0]; // carry out dropped [RQ10]
  endfunction : coam_add16

  coam_state_e state_reg, state_next;
  coam_mode_e mode_reg, mode_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0] idx_reg, idx_next, acc_reg, acc_next, hi_reg, hi_next;
  logic cond_reg, cond_next;
  logic mem_rd_next, done_next, av_next;
  logic [15:0] mem_addr_next, ea_next, npc_next;
  logic [1:0] len_next;
  logic [7:0] imm_next, acc_out_next, idx_out_next;
  logic [15:0] product;

  always_comb begin
    product = 16'({8'h00, acc_reg} * {8'h00, idx_reg}); // [RQ9]
    state_next = state_reg;
    mode_next = mode_reg;
    pc_next = pc_reg;
    idx_next = idx_reg;
    acc_next = acc_reg;
    hi_next = hi_reg;
    cond_next = cond_reg;
    mem_rd_next = 1'b0;
    mem_addr_next = mem_addr;
    done_next = 1'b0;
    av_next = addr_valid;
    ea_next = eff_addr;
    npc_next = next_pc;
    len_next = inst_len;
    imm_next = imm_data;
    acc_out_next = acc_out;
    idx_out_next = index_out;
    case (state_reg)
      COAM_IDLE: begin
        if (start) begin
          mode_next = mode;
          pc_next = pc;
          idx_next = index_in;
          acc_next = acc_in;
          cond_next = branch_cond;
          case (mode)
            COAM_INH, COAM_IX0, COAM_UNSIGNED_MULTIPLY_OP: state_next = COAM_FIN; // [RQ1] [RQ5] [RQ9]
            default: begin
              mem_rd_next = 1'b1;
              mem_addr_next = coam_add16(pc, COAM_ADDR_ONE);
              state_next = COAM_B1;
            end
          endcase
        end
      end
      COAM_B1: begin
        if (mode_reg == COAM_EXT || mode_reg == COAM_IX2) begin
          mem_rd_next = 1'b1; // [RQ4] [RQ7]
          mem_addr_next = coam_add16(mem_addr, COAM_ADDR_ONE);
          state_next = COAM_B2;
        end else begin
          // single operand byte lands next cycle, taken in fin
          state_next = COAM_FIN;
        end
      end
      COAM_B2: begin
        hi_next = mem_rdata;
        state_next = COAM_FIN;
      end
      COAM_FIN: begin
        done_next = 1'b1;
        av_next = 1'b1;
        imm_next = 8'h00;
        acc_out_next = acc_reg;
        idx_out_next = idx_reg;
        case (mode_reg)
          COAM_INH: begin
            len_next = COAM_LEN_ONE; // [RQ1]
            av_next = 1'b0;
            ea_next = 16'h0000;
          end
          COAM_UNSIGNED_MULTIPLY_OP: begin
            len_next = COAM_LEN_ONE;
            av_next = 1'b0;
            ea_next = 16'h0000;
            idx_out_next = product[15:8]; // [RQ9]
            acc_out_next = product[7:0]; // [RQ9]
          end
          COAM_IMM: begin
            len_next = COAM_LEN_TWO; // [RQ2]
            av_next = 1'b0;
            ea_next = 16'h0000;
            imm_next = mem_rdata; // [RQ2]
          end
          COAM_DIR: begin
            len_next = COAM_LEN_TWO;
            ea_next = {COAM_ZERO_PAGE, mem_rdata}; // [RQ3]
          end
          COAM_EXT: begin
            len_next = COAM_LEN_THREE;
            ea_next = {hi_reg, mem_rdata}; // [RQ4]
          end
          COAM_IX0: begin
            len_next = COAM_LEN_ONE;
            ea_next = {COAM_ZERO_PAGE, idx_reg}; // [RQ5]
          end
          COAM_IX1: begin
            len_next = COAM_LEN_TWO;
            ea_next = {7'h00, 9'({1'b0, mem_rdata} + {1'b0, idx_reg})}; // [RQ6]
          end
          COAM_IX2: begin
            len_next = COAM_LEN_THREE;
            ea_next = coam_add16({hi_reg, mem_rdata}, {COAM_ZERO_PAGE, idx_reg}); // [RQ7] [RQ10]
          end
          default: begin
            len_next = COAM_LEN_TWO;
            av_next = 1'b0;
            ea_next = 16'h0000;
          end
        endcase
        npc_next = coam_add16(pc_reg, {14'h0000, len_next});
        if (mode_reg == COAM_REL && cond_reg)
          npc_next = coam_add16(npc_next, {{8{mem_rdata[7]}}, mem_rdata}); // [RQ8] [RQ10]
        state_next = COAM_IDLE;
      end
      default: state_next = COAM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= COAM_IDLE;
      mode_reg <= COAM_INH;
      pc_reg <= 16'h0000;
      idx_reg <= 8'h00;
      acc_reg <= 8'h00;
      hi_reg <= 8'h00;
      cond_reg <= 1'b0;
      mem_rd <= 1'b0;
      mem_addr <= 16'h0000;
      done <= 1'b0;
      addr_valid <= 1'b0;
      eff_addr <= 16'h0000;
      next_pc <= 16'h0000;
      inst_len <= 2'h0;
      imm_data <= 8'h00;
      acc_out <= 8'h00;
      index_out <= 8'h00;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      pc_reg <= pc_next;
      idx_reg <= idx_next;
      acc_reg <= acc_next;
      hi_reg <= hi_next;
      cond_reg <= cond_next;
      mem_rd <= mem_rd_next;
      mem_addr <= mem_addr_next;
      done <= done_next;
      addr_valid <= av_next;
      eff_addr <= ea_next;
      next_pc <= npc_next;
      inst_len <= len_next;
      imm_data <= imm_next;
      acc_out <= acc_out_next;
      index_out <= idx_out_next;
    end
  end

  // assertions
  sequence coam_req_s(coam_mode_e m);
    state_reg == COAM_IDLE && start && mode == m;
  endsequence

  inh_len_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ1]
    coam_req_s(COAM_INH) |-> !mem_rd ##1 !mem_rd ##1 (done && inst_len == COAM_LEN_ONE && !addr_valid))
    else $error("inherent fetched or wrong length");
  imm_len_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ2]
    coam_req_s(COAM_IMM) |-> ##3 (done && inst_len == COAM_LEN_TWO && !addr_valid && imm_data == $past(mem_rdata)))
    else $error("immediate operand wrong");
  dir_addr_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ3]
    coam_req_s(COAM_DIR) |-> ##3 (done && eff_addr[15:8] == COAM_ZERO_PAGE && eff_addr[7:0] == $past(mem_rdata)))
    else $error("direct address wrong");
  ext_fetch_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ4]
    coam_req_s(COAM_EXT) |-> ##1 (mem_rd && mem_addr == 16'($past(pc) + 16'(COAM_LEN_ONE)))
      ##1 (mem_rd && mem_addr == 16'($past(pc, 2) + 16'(COAM_LEN_TWO))))
    else $error("extended fetch address wrong");
  ext_addr_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ4]
    coam_req_s(COAM_EXT) |-> ##4 (done && inst_len == COAM_LEN_THREE && eff_addr == {$past(mem_rdata, 2), $past(mem_rdata)}))
    else $error("extended address wrong");
  ix0_addr_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ5]
    coam_req_s(COAM_IX0) |-> ##2 (done && eff_addr == {8'h00, $past(index_in, 2)}))
    else $error("indexed no offset wrong");
  ix1_addr_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ6]
    coam_req_s(COAM_IX1) |-> ##3 (done && eff_addr == 16'($past(index_in, 3)) + 16'($past(mem_rdata))))
    else $error("indexed 8-bit sum wrong");
  ix2_addr_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ7]
    coam_req_s(COAM_IX2) |-> ##4 (done && eff_addr == 16'({$past(mem_rdata, 2), $past(mem_rdata)} + 16'($past(index_in, 4)))))
    else $error("indexed 16-bit sum wrong");
  rel_pc_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ8]
    coam_req_s(COAM_REL) |-> ##3 (done && next_pc == 16'($past(pc, 3) + 16'(COAM_LEN_TWO) +
      ($past(branch_cond, 3) ? {{8{$past(mem_rdata[7])}}, $past(mem_rdata)} : 16'h0000))))
    else $error("branch target wrong");
  multiply_res_a: assert property (@(posedge clk) disable iff (!reset_n) // [RQ9]
    coam_req_s(COAM_UNSIGNED_MULTIPLY_OP) |-> ##2 (done &&
      {index_out, acc_out} == 16'($past(acc_in, 2)) * 16'($past(index_in, 2))))
    else $error("multiply result wrong");
endmodule : coam_operand_addr

//--- verification/coam_mem_model.sv
/*
  memory model for the operand fetch port.
  assumes registered read strobes; data holds two cycles, then toggles.
*/
`timescale 1ns/1ps
module coam_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // read port
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata
);
  logic age_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_rdata <= 8'h00;
      age_reg <= 1'b0;
    end else if (mem_rd) begin
      mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8];
      age_reg <= 1'b0;
    end else if (age_reg) begin
      mem_rdata <= ~mem_rdata;
    end else begin
      age_reg <= 1'b1;
    end
  end
endmodule : coam_mem_model

//--- verification/testbench.sv
/*
  self-checking bench for the operand address block.
  assumes the memory model answers one cycle after each read strobe.
*/
`timescale 1ns/1ps
module testbench;
  import coam_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  coam_mode_e mode = COAM_INH;
  logic [15:0] pc = 16'h0000;
  logic [7:0] index_in = 8'h00;
  logic [7:0] acc_in = 8'h00;
  logic branch_cond = 1'b0;
  logic mem_rd, done, addr_valid;
  logic [15:0] mem_addr, eff_addr, next_pc;
  logic [7:0] mem_rdata, imm_data, acc_out, index_out;
  logic [1:0] inst_len;
  logic [63:0] seen;
  int fails = 0;
  int comparisons = 0;
  coam_operand_addr u_coam_operand_addr (.clk(clk), .reset_n(reset_n), .start(start), .mode(mode), .pc(pc),
    .index_in(index_in), .acc_in(acc_in), .branch_cond(branch_cond), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .done(done), .inst_len(inst_len), .addr_valid(addr_valid), .eff_addr(eff_addr),
    .imm_data(imm_data), .next_pc(next_pc), .acc_out(acc_out), .index_out(index_out));
  coam_mem_model u_coam_mem_model (.clk(clk), .reset_n(reset_n), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  initial begin
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction : mb
  function automatic logic [63:0] ex(input logic [3:0] lat, input logic [1:0] len, input logic av,
    input logic [15:0] ea, input logic [7:0] imm, input logic [15:0] npc, input logic [7:0] a, x);
    return {1'b0, lat, len, av, ea, imm, npc, a, x};
  endfunction : ex
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic close_out;
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic run(input coam_mode_e m, input logic [15:0] p, input logic [7:0] x, a, input logic c);
    int lat;
    lat = 1;
    @(posedge clk);
    start <= 1'b1;
    mode <= m;
    pc <= p;
    index_in <= x;
    acc_in <= a;
    branch_cond <= c;
    @(posedge clk);
    start <= 1'b0;
    while (done !== 1'b1 && lat < 10) begin
      @(posedge clk);
      #1;
      lat++;
    end
    seen = {1'b0, lat[3:0], inst_len, addr_valid, eff_addr, imm_data, next_pc, acc_out, index_out};
  endtask : run
  task automatic t_inh;
    run(COAM_INH, 16'h1234, 8'h5a, 8'ha5, 1'b0);
    check(seen, ex(4'h2, COAM_LEN_ONE, 1'b0, 16'h0000, 8'h00, 16'h1235, 8'ha5, 8'h5a));
  endtask : t_inh
  task automatic t_imm;
    run(COAM_IMM, 16'h2000, 8'h11, 8'h22, 1'b0);
    check(seen, ex(4'h3, COAM_LEN_TWO, 1'b0, 16'h0000, mb(16'h2001), 16'h2002, 8'h22, 8'h11));
  endtask : t_imm
  task automatic t_dir;
    run(COAM_DIR, 16'h3456, 8'h33, 8'h44, 1'b0);
    check(seen, ex(4'h3, COAM_LEN_TWO, 1'b1, {8'h00, mb(16'h3457)}, 8'h00, 16'h3458, 8'h44, 8'h33));
  endtask : t_dir
  task automatic t_ext;
    run(COAM_EXT, 16'h12fe, 8'h01, 8'h02, 1'b0);
    check(seen, ex(4'h4, COAM_LEN_THREE, 1'b1, 16'hed13, 8'h00, 16'h1301, 8'h02, 8'h01));
  endtask : t_ext
  task automatic t_ix0;
    run(COAM_IX0, 16'h4000, 8'hc3, 8'h07, 1'b0);
    check(seen, ex(4'h2, COAM_LEN_ONE, 1'b1, 16'h00c3, 8'h00, 16'h4001, 8'h07, 8'hc3));
  endtask : t_ix0
  task automatic t_ix1;
    run(COAM_IX1, 16'h00fe, 8'hff, 8'h09, 1'b0);
    check(seen, ex(4'h3, COAM_LEN_TWO, 1'b1, 16'h01fe, 8'h00, 16'h0100, 8'h09, 8'hff));
  endtask : t_ix1
  task automatic t_ix2;
    run(COAM_IX2, 16'hfeff, 8'h10, 8'h0a, 1'b0);
    check(seen, ex(4'h4, COAM_LEN_THREE, 1'b1, 16'h000e, 8'h00, 16'hff02, 8'h0a, 8'h10));
  endtask : t_ix2
  task automatic t_rel;
    run(COAM_REL, 16'h00f0, 8'h01, 8'h02, 1'b1);
    check(seen, ex(4'h3, COAM_LEN_TWO, 1'b0, 16'h0000, 8'h00, 16'h00e3, 8'h02, 8'h01));
    run(COAM_REL, 16'hfff0, 8'h01, 8'h02, 1'b1);
    check(seen, ex(4'h3, COAM_LEN_TWO, 1'b0, 16'h0000, 8'h00, 16'h0000, 8'h02, 8'h01));
    run(COAM_REL, 16'h00f0, 8'h01, 8'h02, 1'b0);
    check(seen, ex(4'h3, COAM_LEN_TWO, 1'b0, 16'h0000, 8'h00, 16'h00f2, 8'h02, 8'h01));
  endtask : t_rel
  task automatic t_multiply;
    run(COAM_UNSIGNED_MULTIPLY_OP, 16'h5000, 8'hff, 8'hff, 1'b0);
    check(seen, ex(4'h2, COAM_LEN_ONE, 1'b0, 16'h0000, 8'h00, 16'h5001, 8'h01, 8'hfe));
    run(COAM_UNSIGNED_MULTIPLY_OP, 16'h5000, 8'h0b, 8'h0c, 1'b0);
    check(seen, ex(4'h2, COAM_LEN_ONE, 1'b0, 16'h0000, 8'h00, 16'h5001, 8'h84, 8'h00));
  endtask : t_multiply
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_inh();
    t_imm();
    t_dir();
    t_ext();
    t_ix0();
    t_ix1();
    t_ix2();
    t_rel();
    t_multiply();
    close_out();
  end
  initial begin
    #100000;
    fails++;
    close_out();
  end
endmodule : testbench
